//--- efp_pkg.sv
/*
 * efp_pkg: shared constants and types for the embedded flash program control block.
 * Assumes a 16-bit core memory bus and an I/O bus with 16-bit port addresses.
 */
package efp_pkg;
	localparam int unsigned DATA_W      = 16;
	localparam int unsigned ADDR_W      = 16;
	// register offsets, low two address bits
	localparam logic [1:0]  OFS_SEG_CTL = 2'h0;
	localparam logic [1:0]  OFS_TEST    = 2'h1;
	localparam logic [1:0]  OFS_WADDR   = 2'h2;
	localparam logic [1:0]  OFS_WDATA   = 2'h3;
	// segment control field positions
	localparam int unsigned POS_RUN     = 0;
	localparam int unsigned POS_OP_LO   = 1;
	localparam int unsigned POS_VER_LO  = 3;
	localparam int unsigned POS_KEY_LO  = 5;
	localparam int unsigned POS_KEY_HI  = 6;
	localparam int unsigned POS_SEG_LO  = 8;
	localparam logic [15:0] SEG_CTL_RST = 16'h0000;
	localparam logic [15:0] ERASE_DATA  = 16'hffff;
	localparam logic [15:0] MODE_PORT   = 16'hff0f;
	localparam logic [4:0]  TEST_RST    = 5'h00;
	localparam logic [15:0] SEG_SIZE    = 16'h0800;
	// host-side pulse time
	localparam int unsigned WRITE_PULSE_US = 100;
	localparam int unsigned CLK_MHZ        = 25;
	localparam int unsigned WRITE_PULSE_CYC = WRITE_PULSE_US * CLK_MHZ;

	typedef enum logic [1:0] {
		OP_NONE  = 2'h0,
		OP_ERASE = 2'h1,
		OP_WRITE = 2'h2,
		OP_DRW   = 2'h3
	} efp_op_t;

	typedef enum logic [1:0] {
		VER_NORMAL  = 2'h0,
		VER_ONES    = 2'h1,
		VER_ZEROS   = 2'h2,
		VER_INVERSE = 2'h3
	} efp_ver_t;
endpackage

//--- efp_bus_if.sv
/*
 * efp_bus_if: core memory bus and I/O bus joining the host core end and the flash control end.
 * Assumes one clock; strobes last one cycle.
 */
`timescale 1ns/1ns
interface efp_bus_if;
	logic        mem_wr;
	logic        mem_rd;
	logic [15:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic        io_wr;
	logic        io_rd;
	logic [15:0] io_addr;

	modport core (output mem_wr, mem_rd, mem_addr, mem_wdata, io_wr, io_rd, io_addr,
		input mem_rdata);
	modport flash (input mem_wr, mem_rd, mem_addr, mem_wdata, io_wr, io_rd, io_addr,
		output mem_rdata);
endinterface

//--- efp_flash_ctl.sv
/*
 * efp_flash_ctl: flash module control registers, access mode switch and array request outputs.
 * Assumes the core keeps its own rules (R2,R3,R4,R14,R20); array data arrives on arr_rdata_i.
 * Step sequences and analog pulse timing stay in core software.
 */
// What this block and the core software do
// R1: one write operation for clear, code, boost
// R2: software programs at most 8 bits per write
// R3: software verifies each word, masks passing bits
// R4: software times each write pulse 100 us
// R5: port write selects register access mode
// R6: port read restores array access mode
// R7: two low address bits select register, repeating
// R8: test register hidden in normal modes
// R9: segment control layout: enables, keys, verify, op, run
// R10: power-on clear zeroes segment control
// R11: eight segment enables, one per 2K segment
// R12: op field: none, erase, write, recovery write
// R13: verify field selects array read mode
// R14: start needs run with keys 1 0 together
// R15: key bits always read zero
// R16: program/erase need exact control bit patterns
// R17: array changes only while run and not aborted
// R18: non-control bits frozen while run set
// R19: latches locked and array ignored while running
// R20: software clears run together with key bits
// R21: array write captures address and data latches
// R22: erase refused unless data latch is ffff
// R23: qualified op, segments, verify to array
// R24: synchronous register writes, reads show contents
`timescale 1ns/1ns
module efp_flash_ctl (
	input  wire logic                  ref_clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  power_on_clear_i,
	input  wire logic                  abort_run_i,
	input  wire logic                  test_mode_i,
	input  wire logic [15:0]           arr_rdata_i,
	efp_bus_if.flash                   bus,
	output logic                       reg_mode_o,
	output efp_pkg::efp_op_t           arr_op_o,
	output logic                       arr_req_o,
	output logic [7:0]                 segment_enables_o,
	output efp_pkg::efp_ver_t          arr_verify_o,
	output logic [15:0]                arr_addr_o,
	output logic [15:0]                arr_data_o
);
	import efp_pkg::*;

	logic [15:0] segment_control;
	logic [4:0]  factory_test;
	logic [15:0] write_address_latch;
	logic [15:0] write_data_latch;
	logic        run_now;
	logic        reg_wr;
	logic        arr_wr;
	logic        io_enter;
	logic        io_leave;
	logic        hit_seg;
	logic        hit_test;
	logic        hit_waddr;
	logic        hit_wdata;
	logic [1:0]  ofs;
	logic [15:0] wd;
	logic        keys_ok;
	logic        verify_idle;
	logic        start_ok;
	efp_op_t     next_op;

	// run, op and verify fields only; reserved and key bits are never stored
	function automatic logic [7:0] ctl_byte(input logic [15:0] w, input logic run);
		ctl_byte = {1'b0, 2'b00, w[POS_OP_LO +: 4], run};
	endfunction

	// mode port decode
	assign io_enter    = bus.io_wr && bus.io_addr == MODE_PORT;
	assign io_leave    = bus.io_rd && bus.io_addr == MODE_PORT;
	assign ofs         = bus.mem_addr[1:0]; // R7
	assign reg_wr      = bus.mem_wr && reg_mode_o;
	assign arr_wr      = bus.mem_wr && !reg_mode_o;
	assign hit_seg     = reg_wr && ofs == OFS_SEG_CTL;
	assign hit_test    = reg_wr && ofs == OFS_TEST;
	assign hit_waddr   = reg_wr && ofs == OFS_WADDR;
	assign hit_wdata   = reg_wr && ofs == OFS_WDATA;
	assign wd          = bus.mem_wdata;
	assign run_now     = segment_control[POS_RUN];
	assign keys_ok     = wd[POS_KEY_HI] && !wd[POS_KEY_LO]; // R14
	assign verify_idle = wd[POS_VER_LO +: 2] == 2'b00;
	assign next_op     = efp_op_t'(wd[POS_OP_LO +: 2]);
	// erase refuses a wrong data latch; no start with a margin read selected
	assign start_ok = keys_ok && wd[POS_RUN] && verify_idle && (next_op != OP_NONE)
		&& !(next_op == OP_ERASE && write_data_latch != ERASE_DATA); // R22 R16

	// access mode: io write enters register mode, io read leaves it
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			reg_mode_o <= 1'b0;
		end else if (io_enter) begin
			reg_mode_o <= 1'b1; // R5
		end else if (io_leave) begin
			reg_mode_o <= 1'b0; // R6
		end
	end

	// segment control; key bits never stored, so they read zero
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || power_on_clear_i) begin
			segment_control <= SEG_CTL_RST; // R10
		end else if (hit_seg) begin // R24
			if (run_now) begin
				// only control bits move while running; stop needs keys with run low
				if (!wd[POS_RUN] && keys_ok) begin // R18
					segment_control[7:0] <= ctl_byte(wd, 1'b0); // R9
				end
			end else begin
				// enables load only here, so a stop write cannot change them
				segment_control <= {wd[15:POS_SEG_LO], ctl_byte(wd, start_ok)}; // R14 R11
			end
		end
	end

	// address latch: bus capture in array mode, direct in register mode, locked while running
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			write_address_latch <= 16'h0000;
		end else if (!run_now) begin // R19
			if (arr_wr) begin
				write_address_latch <= bus.mem_addr; // R21
			end else if (hit_waddr) begin
				write_address_latch <= wd;
			end
		end
	end

	// data latch: same capture rules; erase start checks it
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			write_data_latch <= 16'h0000;
		end else if (!run_now) begin // R19
			if (arr_wr) begin
				write_data_latch <= wd; // R21
			end else if (hit_wdata) begin
				write_data_latch <= wd;
			end
		end
	end

	// test register: written only in test mode and while idle
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			factory_test <= TEST_RST;
		end else if (hit_test && test_mode_i && !run_now) begin // R8
			factory_test <= wd[4:0];
		end
	end

	// read data, registered one cycle after the read strobe
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			bus.mem_rdata <= 16'h0000;
		end else if (bus.mem_rd) begin
			if (reg_mode_o) begin
				unique case (ofs)
					OFS_SEG_CTL: bus.mem_rdata <= segment_control & 16'hff9f; // R15
					OFS_TEST:    bus.mem_rdata <= test_mode_i ? {11'h000, factory_test}
						: 16'h0000; // R8
					OFS_WADDR:   bus.mem_rdata <= write_address_latch;
					OFS_WDATA:   bus.mem_rdata <= write_data_latch;
				endcase
			end else begin
				// indeterminate while running; array data passes regardless
				bus.mem_rdata <= arr_rdata_i; // R19
			end
		end
	end

	// run request to the array, dropped on abort without touching the run bit
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			arr_req_o <= 1'b0;
		end else begin
			arr_req_o <= run_now && !abort_run_i; // R17 R23
		end
	end

	// array side: one write path for clear, code and boost steps
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			arr_op_o          <= OP_NONE;
			segment_enables_o <= 8'h00;
			arr_verify_o      <= VER_NORMAL;
		end else begin
			arr_op_o          <= efp_op_t'(segment_control[POS_OP_LO +: 2]); // R12 R1
			segment_enables_o <= segment_control[15:POS_SEG_LO]; // R11
			arr_verify_o      <= efp_ver_t'(segment_control[POS_VER_LO +: 2]); // R13
		end
	end

	// latch copies for the array; they only move while no operation runs
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			arr_addr_o <= 16'h0000;
			arr_data_o <= 16'h0000;
		end else begin
			arr_addr_o <= write_address_latch;
			arr_data_o <= write_data_latch;
		end
	end
endmodule

//--- efp_core_host.sv
/*
 * efp_core_host: core-side sequencer issuing bus cycles and a timed write program step.
 * Assumes the flash end answers reads one cycle after the strobe.
 */
`timescale 1ns/1ns
module efp_core_host #(
	parameter int unsigned PULSE_CYC = efp_pkg::WRITE_PULSE_CYC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [2:0]  cmd_kind_i,
	input  wire logic [15:0] cmd_addr_i,
	input  wire logic [15:0] cmd_data_i,
	efp_bus_if.core          bus,
	output logic             busy_o,
	output logic             rd_valid_o,
	output logic [15:0]      rd_data_o
);
	import efp_pkg::*;

	// kinds: 0 mem write, 1 mem read, 2 enter regs, 3 leave regs, 4 timed program pulse
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_HOLD = 4'h4,
		ST_STOP = 4'h8
	} efp_hst_t;

	efp_hst_t    state;
	logic [31:0] cnt;
	logic        rd_pend;
	logic        rd_wait;
	logic [15:0] ctl_word;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			cnt <= 32'h0;
			busy_o <= 1'b0;
			rd_pend <= 1'b0;
			ctl_word <= 16'h0000;
			bus.mem_wr <= 1'b0;
			bus.mem_rd <= 1'b0;
			bus.mem_addr <= 16'h0000;
			bus.mem_wdata <= 16'h0000;
			bus.io_wr <= 1'b0;
			bus.io_rd <= 1'b0;
			bus.io_addr <= 16'h0000;
		end else begin
			bus.mem_wr <= 1'b0;
			bus.mem_rd <= 1'b0;
			bus.io_wr <= 1'b0;
			bus.io_rd <= 1'b0;
			rd_pend <= 1'b0;
			unique case (state)
				ST_IDLE: if (cmd_valid_i) begin
					bus.mem_addr <= cmd_addr_i;
					bus.mem_wdata <= cmd_data_i;
					bus.io_addr <= MODE_PORT;
					unique case (cmd_kind_i)
						3'h0: bus.mem_wr <= 1'b1;
						3'h1: begin
							bus.mem_rd <= 1'b1;
							rd_pend <= 1'b1;
						end
						3'h2: bus.io_wr <= 1'b1;
						3'h3: bus.io_rd <= 1'b1;
						default: begin
							// start with keys 1 0 and run in one write
							ctl_word <= cmd_data_i & 16'hff1e; // R2 R14
							bus.mem_addr <= 16'h0000;
							bus.mem_wdata <= (cmd_data_i & 16'hff1e) | 16'h0041;
							bus.mem_wr <= 1'b1;
							busy_o <= 1'b1;
							// start write is the first pulse cycle; stop lands after PULSE_CYC
							cnt <= 32'h1;
							state <= ST_HOLD;
						end
					endcase
				end
				ST_HOLD: begin
					cnt <= cnt + 32'h1;
					if (cnt + 32'h1 >= PULSE_CYC) begin // R4
						state <= ST_STOP;
					end
				end
				ST_STOP: begin
					// clear run with the keys in the same write
					bus.mem_wdata <= ctl_word | 16'h0040; // R20
					bus.mem_wr <= 1'b1;
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					busy_o <= 1'b0;
					state <= ST_IDLE; // R3 verify is left to the command source
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rd_wait <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 16'h0000;
		end else begin
			// read data stands one edge after the strobe edge
			rd_wait <= rd_pend;
			rd_valid_o <= rd_wait;
			rd_data_o <= rd_wait ? bus.mem_rdata : rd_data_o;
		end
	end
endmodule

//--- efp_flash_sva.sv
/* efp_flash_sva: checks on the bus joining core end and flash end.
   Assumes strobes of one cycle and reads answered one edge later. */
`timescale 1ns/1ns
module efp_flash_sva (
	input wire logic        ref_clk_i,
	input wire logic        srst_i,
	input wire logic        mem_wr,
	input wire logic        mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [15:0] io_addr
);
	import efp_pkg::*;
	logic        reg_mode;
	logic        run;
	logic [15:0] waddr;
	logic [15:0] wdata;
	logic        reg_wr;
	logic        start_ok;
	assign reg_wr = mem_wr && reg_mode;
	assign start_ok = mem_wdata[0] && mem_wdata[6:5] == 2'h2 && mem_wdata[2:1] != 2'h0
		&& mem_wdata[4:3] == 2'h0 && (mem_wdata[2:1] != 2'h1 || wdata == ERASE_DATA);
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) reg_mode <= 1'b0;
		else if (io_wr && io_addr == MODE_PORT) reg_mode <= 1'b1;
		else if (io_rd && io_addr == MODE_PORT) reg_mode <= 1'b0;
	end
	// power-on clear is only pulsed while idle, so it is not mirrored
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) run <= 1'b0;
		else if (reg_wr && mem_addr[1:0] == OFS_SEG_CTL)
			run <= run ? !(!mem_wdata[0] && mem_wdata[6:5] == 2'h2) : start_ok;
	end
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			waddr <= 16'h0000;
			wdata <= 16'h0000;
		end else if (mem_wr && !run && !reg_mode) begin
			waddr <= mem_addr;
			wdata <= mem_wdata;
		end else if (reg_wr && !run && mem_addr[1:0] == OFS_WADDR) waddr <= mem_wdata;
		else if (reg_wr && !run && mem_addr[1:0] == OFS_WDATA) wdata <= mem_wdata;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	a_keys_read_zero: assert property (mem_rd && reg_mode && mem_addr[1:0] == 2'h0
		|=> mem_rdata[6:5] == 2'h0) else $error("key bits read back nonzero");
	a_reserved_bit_zero: assert property (mem_rd && reg_mode && mem_addr[1:0] == 2'h0
		|=> !mem_rdata[7]) else $error("reserved bit read back set");
	a_run_bit_state: assert property (mem_rd && reg_mode && mem_addr[1:0] == 2'h0
		|=> mem_rdata[0] == run) else $error("run bit differs from start rules");
	a_waddr_latch_value: assert property (mem_rd && reg_mode && mem_addr[1:0] == 2'h2
		|=> mem_rdata == waddr) else $error("address latch value wrong");
	a_wdata_latch_value: assert property (mem_rd && reg_mode && mem_addr[1:0] == 2'h3
		|=> mem_rdata == wdata) else $error("data latch value wrong");
	a_read_one_cycle: assert property (mem_rd |=> !mem_rd)
		else $error("read strobe longer than one cycle");
	a_write_one_cycle: assert property ($rose(mem_wr) |=> !mem_wr)
		else $error("write strobe longer than one cycle");
	a_io_alone: assert property (io_wr || io_rd |-> !mem_wr && !mem_rd)
		else $error("port and memory strobes together");
endmodule

//--- test_embedded_flash_program_control.sv
/* test_embedded_flash_program_control: core end and flash end joined by the bus.
   Assumes a 25 MHz clock and a shortened write pulse of 10 cycles. */
`timescale 1ns/1ns
module test_embedded_flash_program_control;
	import efp_pkg::*;
	localparam int unsigned PULSE = 10;
	logic              ref_clk_i = 1'b0;
	logic              srst_i = 1'b1;
	logic              poc = 1'b0;
	logic              abort = 1'b0;
	logic [15:0]       arr_rdata = 16'h5a3c;
	logic              cmd_valid = 1'b0;
	logic [2:0]        cmd_kind = 3'h0;
	logic [15:0]       cmd_addr = 16'h0000;
	logic [15:0]       cmd_data = 16'h0000;
	logic              reg_mode, arr_req, busy, rd_valid;
	efp_op_t           arr_op;
	efp_ver_t          arr_ver;
	logic [7:0]        seg_en;
	logic [15:0]       arr_addr, arr_data, rd_data, last_rd;
	int                mismatches = 0;
	int                checks_done = 0;
	efp_bus_if u_bus ();
	efp_flash_ctl u_efp_flash_ctl (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.power_on_clear_i(poc), .abort_run_i(abort), .test_mode_i(1'b0),
		.arr_rdata_i(arr_rdata), .bus(u_bus), .reg_mode_o(reg_mode), .arr_op_o(arr_op),
		.arr_req_o(arr_req), .segment_enables_o(seg_en), .arr_verify_o(arr_ver),
		.arr_addr_o(arr_addr), .arr_data_o(arr_data));
	efp_core_host #(.PULSE_CYC(PULSE)) u_efp_core_host (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_addr_i(cmd_addr),
		.cmd_data_i(cmd_data), .bus(u_bus), .busy_o(busy), .rd_valid_o(rd_valid),
		.rd_data_o(rd_data));
	efp_flash_sva u_efp_flash_sva (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.mem_wr(u_bus.mem_wr), .mem_rd(u_bus.mem_rd), .mem_addr(u_bus.mem_addr),
		.mem_wdata(u_bus.mem_wdata), .mem_rdata(u_bus.mem_rdata), .io_wr(u_bus.io_wr),
		.io_rd(u_bus.io_rd), .io_addr(u_bus.io_addr));
	always #20 ref_clk_i = ~ref_clk_i;
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmd(input logic [2:0] kind, input logic [15:0] addr, input logic [15:0] data);
		@(posedge ref_clk_i);
		cmd_valid <= 1'b1;
		cmd_kind <= kind;
		cmd_addr <= addr;
		cmd_data <= data;
		@(posedge ref_clk_i);
		cmd_valid <= 1'b0;
		repeat (5) begin
			@(posedge ref_clk_i);
			#1;
			if (rd_valid === 1'b1) last_rd = rd_data;
		end
	endtask
	task automatic t_mode;
		cmd(1, 16'h0005, 16'h0);
		chk("array read", last_rd, 16'h5a3c);
		cmd(2, MODE_PORT, 16'h0);
		chk("reg mode", 16'(reg_mode), 16'h1);
		cmd(1, 16'h0000, 16'h0);
		chk("seg after reset", last_rd, SEG_CTL_RST);
		cmd(3, MODE_PORT, 16'h0);
		chk("array mode", 16'(reg_mode), 16'h0);
	endtask
	task automatic t_latch;
		cmd(0, 16'h0123, 16'h00ff);
		chk("addr out", arr_addr, 16'h0123);
		chk("data out", arr_data, 16'h00ff);
		cmd(2, MODE_PORT, 16'h0);
		cmd(1, 16'h0106, 16'h0);
		chk("addr latch", last_rd, 16'h0123);
		cmd(0, 16'h0002, 16'h1234);
		cmd(1, 16'h3ffa, 16'h0);
		chk("addr reg", last_rd, 16'h1234);
		cmd(1, 16'h3fff, 16'h0);
		chk("data latch", last_rd, 16'h00ff);
		cmd(0, 16'h0001, 16'h001f);
		cmd(1, 16'h0005, 16'h0);
		chk("test hidden", last_rd, 16'h0000);
	endtask
	task automatic t_fields;
		logic [15:0] v;
		for (int op = 1; op < 4; op++) begin
			for (int ver = 0; ver < 4; ver++) begin
				v = {2'(op), 2'(ver), 2'(ver), 2'(op), 3'h3, 2'(ver), 2'(op), 1'b1};
				cmd(0, 16'h0004, v);
				cmd(1, 16'h0008, 16'h0);
				chk("seg read", last_rd, v & 16'hff1e);
				chk("op out", 16'(arr_op), 16'(op));
				chk("verify out", 16'(arr_ver), 16'(ver));
				chk("seg out", 16'(seg_en), 16'(v[15:8]));
				chk("no start", 16'(arr_req), 16'h0);
			end
		end
	endtask
	task automatic t_run;
		cmd(0, 16'h0000, 16'h0104);
		cmd(0, 16'h0000, 16'h0155);
		chk("margin blocks start", 16'(arr_req), 16'h0);
		cmd(0, 16'h0000, 16'h0145);
		chk("req on", 16'(arr_req), 16'h1);
		chk("op write", 16'(arr_op), 16'(OP_WRITE));
		cmd(0, 16'h0000, 16'h8145);
		chk("seg frozen", 16'(seg_en), 16'h1);
		cmd(0, 16'h0002, 16'hbeef);
		cmd(1, 16'h0002, 16'h0);
		chk("latch locked", last_rd, 16'h1234);
		@(posedge ref_clk_i);
		abort <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk("req aborted", 16'(arr_req), 16'h0);
		abort <= 1'b0;
		cmd(0, 16'h0000, 16'h8144);
		cmd(1, 16'h0000, 16'h0);
		chk("run cleared", last_rd, 16'h0104);
		chk("req off", 16'(arr_req), 16'h0);
	endtask
	task automatic t_erase;
		cmd(0, 16'h0003, 16'h1234);
		cmd(0, 16'h0000, 16'h0143);
		chk("erase refused", 16'(arr_req), 16'h0);
		cmd(0, 16'h0003, ERASE_DATA);
		cmd(0, 16'h0000, 16'h0143);
		chk("erase runs", 16'(arr_req), 16'h1);
		chk("op erase", 16'(arr_op), 16'(OP_ERASE));
		cmd(0, 16'h0000, 16'h0142);
		@(posedge ref_clk_i);
		poc <= 1'b1;
		@(posedge ref_clk_i);
		poc <= 1'b0;
		cmd(1, 16'h0000, 16'h0);
		chk("power clear", last_rd, SEG_CTL_RST);
	endtask
	task automatic t_timed;
		int n;
		int m;
		n = 0;
		m = 0;
		@(posedge ref_clk_i);
		cmd_valid <= 1'b1;
		cmd_kind <= 3'h4;
		cmd_data <= 16'h0104;
		@(posedge ref_clk_i);
		cmd_valid <= 1'b0;
		repeat (40) begin
			@(posedge ref_clk_i);
			#1;
			if (busy === 1'b1) n++;
			if (arr_req === 1'b1) m++;
		end
		chk("busy span", 16'(n), 16'(PULSE));
		chk("req in pulse", 16'(m), 16'(PULSE));
		cmd(1, 16'h0000, 16'h0);
		chk("seg after pulse", last_rd, 16'h0104);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		t_mode();
		t_latch();
		t_fields();
		t_run();
		t_erase();
		t_timed();
		stop_test();
	end
	initial begin
		repeat (3000) @(posedge ref_clk_i);
		mismatches++;
		stop_test();
	end
endmodule
